// ==== design/pstg_chan_if.sv ====
// Signals between the counter core and one start channel
interface pstg_chan_if;
    logic [7:0] count;
    logic       running;
    logic [7:0] compare;
    logic       stop;
    logic       start;
    modport core (output count, output running, output compare, output stop, input start);
    modport chan (input count, input running, input compare, input stop, output start);
endinterface : pstg_chan_if

// ==== design/pstg_channel.sv ====
// One start channel: compare match latch with stop
module pstg_channel (
    input  wire logic   hclk,
    input  wire logic   hresetn,
    pstg_chan_if.chan   ch
);
    logic start_reg;
    logic match;
    logic at_compare;
    logic at_compare_reg;

    // Zero compare never matches, so a channel can stay idle for a whole count
    assign at_compare = ch.running && (ch.compare == ch.count) && (ch.compare != pstg_pkg::COMPARE_RESET);
    // Only the cycle in which the count arrives is a match: a stop written while
    // the count still rests on the compare value must not be undone a cycle later
    assign match = at_compare && !at_compare_reg; // RULE_04 RULE_09

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            at_compare_reg <= 1'b0;
        end else begin
            at_compare_reg <= at_compare;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_reg <= 1'b0;
        end else if (ch.stop) begin
            start_reg <= 1'b0; // RULE_06 RULE_09
        end else if (match) begin
            start_reg <= 1'b1; // RULE_04 RULE_05
        end
    end

    assign ch.start = start_reg;
endmodule // pstg_channel

// ==== design/pstg_pkg.sv ====
// Constants for the pulse start timing generator
package pstg_pkg;
    localparam int unsigned CHANNELS         = 4;
    localparam logic [7:0]  ADDR_TRIG_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_COMPARE0    = 8'h04;
    localparam logic [7:0]  ADDR_MODE_CTRL   = 8'h14;
    localparam logic [7:0]  ADDR_COUNT       = 8'h18;
    localparam int unsigned STOP_LSB         = 12;
    localparam int unsigned CLK_SEL_LSB      = 10;
    localparam int unsigned RUNNING_BIT      = 9;
    localparam int unsigned START_BIT        = 8;
    localparam logic [1:0]  CLK_SEL_RESET    = 2'h0;
    localparam logic [7:0]  COMPARE_RESET    = 8'h00;
    localparam logic [3:0]  SELECT_RESET     = 4'h0;
    localparam logic [7:0]  COUNT_RESET      = 8'h00;
    localparam logic [7:0]  COUNT_MAX        = 8'hFF;
    localparam logic [5:0]  DIV_LAST_2       = 6'h01;
    localparam logic [5:0]  DIV_LAST_8       = 6'h07;
    localparam logic [5:0]  DIV_LAST_32      = 6'h1F;
    localparam logic [5:0]  DIV_LAST_64      = 6'h3F;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
endpackage : pstg_pkg

// ==== design/pstg_top.sv ====
// Pulse start timing generator: AHB-Lite registers, 8-bit upcounter, four start channels
// Operation
// RULE_01: Software reads running flag and initialises only once counter stopped.
// RULE_02: Channel start output passes only when its start source select bit is 1.
// RULE_03: Writing 1 to counter start bit makes the upcounter begin counting.
// RULE_04: Count equal to channel compare value asserts that channel's start signal.
// RULE_05: Asserted start signal stays asserted until software stops that channel.
// RULE_06: Writing 0 to trigger stop bit negates start; writing 1 does nothing.
// RULE_07: Counter halts by itself at 0xFF; new start counts again from zero.
// RULE_08: Clock select codes 00..11 give divide by 2, 8, 32, 64; reset 00.
// RULE_09: Stop write and compare match together leave start signal negated.
// RULE_10: Software programs compare zero for a channel that must not start.
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
module pstg_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [3:0]  start_out
);
    localparam int unsigned N = pstg_pkg::CHANNELS;

    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic [1:0]  clk_sel_reg;
    logic [3:0]  select_reg;
    logic [7:0]  compare_reg [N];
    logic        running_reg;
    logic [7:0]  count_reg;
    logic [5:0]  div_reg;
    logic [5:0]  div_last;
    logic        tick;
    logic        addr_take;
    logic        wr_trig;
    logic        start_req;
    logic [3:0]  stop_req;
    logic [3:0]  chan_start;
    logic [31:0] rd_value;
    logic [7:0]  rd_addr;
    logic        wr_mode;
    logic [1:0]  clk_sel_rd;
    logic [3:0]  select_rd;
    logic [7:0]  compare_rd [N];
    logic        running_rd;
    logic [7:0]  count_rd;

    assign addr_take = hsel && hready && (htrans == pstg_pkg::HTRANS_NONSEQ);
    assign rd_addr   = haddr[7:0];
    assign wr_trig   = wr_pend_reg && (wr_addr_reg == pstg_pkg::ADDR_TRIG_CTRL);
    assign start_req = wr_trig && hwdata[pstg_pkg::START_BIT]; // RULE_03
    assign wr_mode   = wr_pend_reg && (wr_addr_reg == pstg_pkg::ADDR_MODE_CTRL);

    // hsize ignored: every register is one whole word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_take && hwrite;
            wr_addr_reg <= rd_addr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_sel_reg <= pstg_pkg::CLK_SEL_RESET;
            select_reg  <= pstg_pkg::SELECT_RESET;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == pstg_pkg::ADDR_TRIG_CTRL) begin
                clk_sel_reg <= hwdata[pstg_pkg::CLK_SEL_LSB +: 2]; // RULE_08
            end
            if (wr_addr_reg == pstg_pkg::ADDR_MODE_CTRL) begin
                select_reg <= hwdata[3:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < N; i++) begin
                compare_reg[i] <= pstg_pkg::COMPARE_RESET;
            end
        end else if (wr_pend_reg) begin
            for (int i = 0; i < N; i++) begin
                if (wr_addr_reg == pstg_pkg::ADDR_COMPARE0 + 8'(4 * i)) begin
                    compare_reg[i] <= hwdata[7:0];
                end
            end
        end
    end

    // Stop bits act on a written 0 only
    assign stop_req = wr_trig ? ~hwdata[pstg_pkg::STOP_LSB +: 4] : 4'h0; // RULE_06

    always_comb begin
        unique case (clk_sel_reg)
            2'h0: div_last = pstg_pkg::DIV_LAST_2;
            2'h1: div_last = pstg_pkg::DIV_LAST_8;
            2'h2: div_last = pstg_pkg::DIV_LAST_32;
            2'h3: div_last = pstg_pkg::DIV_LAST_64;
        endcase
    end

    assign tick = running_reg && (div_reg == div_last); // RULE_08

    // Prescaler restarts with the counter so the first step is a full divided period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= 6'h00;
        end else if (start_req || !running_reg || tick) begin
            div_reg <= 6'h00;
        end else begin
            div_reg <= div_reg + 6'h01;
        end
    end

    // A start while running restarts only the prescaler; software must wait for the running flag to drop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            running_reg <= 1'b0;
            count_reg   <= pstg_pkg::COUNT_RESET;
        end else if (start_req && !running_reg) begin
            running_reg <= 1'b1; // RULE_03
            count_reg   <= pstg_pkg::COUNT_RESET; // RULE_07
        end else if (tick) begin
            if (count_reg == pstg_pkg::COUNT_MAX) begin
                running_reg <= 1'b0; // RULE_07
            end else begin
                count_reg <= count_reg + 8'h01;
            end
        end
    end

    for (genvar g = 0; g < N; g++) begin : g_chan
        pstg_chan_if link ();
        assign link.count   = count_reg;
        assign link.running = running_reg;
        assign link.compare = compare_reg[g];
        assign link.stop    = stop_req[g];
        assign chan_start[g] = link.start;
        pstg_channel u_chan (
            .hclk    (hclk),
            .hresetn (hresetn),
            .ch      (link)
        );
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_out <= 4'h0;
        end else begin
            start_out <= chan_start & select_reg; // RULE_02
        end
    end

    // A read whose address phase meets the data phase of a write must see the word
    // being written, so the pending write is forwarded instead of stalling the bus
    always_comb begin
        clk_sel_rd = clk_sel_reg;
        select_rd  = select_reg;
        running_rd = running_reg;
        count_rd   = count_reg;
        for (int i = 0; i < N; i++) begin
            compare_rd[i] = compare_reg[i];
        end
        if (wr_trig) begin
            clk_sel_rd = hwdata[pstg_pkg::CLK_SEL_LSB +: 2];
        end
        if (start_req && !running_reg) begin
            running_rd = 1'b1;
            count_rd   = pstg_pkg::COUNT_RESET;
        end
        if (wr_mode) begin
            select_rd = hwdata[3:0];
        end
        for (int i = 0; i < N; i++) begin
            if (wr_pend_reg && (wr_addr_reg == pstg_pkg::ADDR_COMPARE0 + 8'(4 * i))) begin
                compare_rd[i] = hwdata[7:0];
            end
        end
    end

    always_comb begin
        rd_value = 32'h0000_0000;
        if (rd_addr == pstg_pkg::ADDR_TRIG_CTRL) begin
            rd_value[pstg_pkg::STOP_LSB +: 4]    = 4'hF;
            rd_value[pstg_pkg::CLK_SEL_LSB +: 2] = clk_sel_rd;
            rd_value[pstg_pkg::RUNNING_BIT]      = running_rd; // RULE_01
        end else if (rd_addr == pstg_pkg::ADDR_MODE_CTRL) begin
            rd_value[3:0] = select_rd;
        end else if (rd_addr == pstg_pkg::ADDR_COUNT) begin
            rd_value[7:0] = count_rd;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (rd_addr == pstg_pkg::ADDR_COMPARE0 + 8'(4 * i)) begin
                    rd_value[7:0] = compare_rd[i];
                end
            end
        end
    end

    // Read data is captured in the address phase so hrdata comes from a flop with no wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_take && !hwrite) begin
                hrdata <= rd_value;
            end
        end
    end
endmodule // pstg_top

// ==== tb/pstg_bench.sv ====
// Self-checking bench for the pulse start timing generator
module pstg_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} pstg_row_t;
    // Reset values first, then write and read back; narrow fields keep only their bits
    pstg_row_t   rows [11] = '{'{0, 8'h00, 0, 32'hF000}, '{0, 8'h04, 0, 0}, '{0, 8'h14, 0, 0}, '{0, 8'h18, 0, 0},
        '{1, 8'h04, 32'hFFFF_FF03, 3}, '{1, 8'h08, 5, 5}, '{1, 8'h0C, 0, 0}, '{1, 8'h10, 32'hFF, 32'hFF},
        '{1, 8'h14, 32'hFFFF_FFFD, 32'hD}, '{1, 8'h1C, 32'h1234, 0}, '{1, 8'h18, 32'h55, 0}};
    int          div [4] = '{2, 8, 32, 64};
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, p;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [3:0]  start_out, pulse;
    int          n_fail = 0, comparisons = 0, n;
    pstg_top i_pstg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .start_out(start_out));
    pstg_pulse_model i_pstg_pulse_model (.hclk(hclk), .hresetn(hresetn), .start(start_out), .pulse(pulse));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic guard(input int k, input int lim);
        if (k >= lim) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        guard(k, 50);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= pstg_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask
    // Software may only touch the settings once the counter has stopped
    task automatic poll();
        int k;
        k = 0;
        do begin
            xfer(1'b0, pstg_pkg::ADDR_TRIG_CTRL, 0, rd);
            k++;
        end while (rd[pstg_pkg::RUNNING_BIT] !== 1'b0 && k < 9000);
        guard(k, 9000);
    endtask
    initial forever #4 hclk = ~hclk;
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) xfer(1'b1, rows[i].a, rows[i].d, rd);
            xfer(1'b0, rows[i].a, 0, rd);
            chk($sformatf("reg %h", rows[i].a), rows[i].e, rd);
        end
        for (int cs = 0; cs < 4; cs++) begin
            @(posedge hclk);
            poll();
            xfer(1'b1, 8'h00, 32'hF100 | (cs << 10), rd);
            n = 0;
            while (start_out[0] !== 1'b1 && n < 400) begin
                @(negedge hclk);
                n++;
            end
            guard(n, 400);
            chk("start delay", 3 * div[cs] + 3, n);
            p = pulse[0];
            @(negedge hclk);
            chk("pulse", 32'(!p), pulse[0]);
            @(posedge hclk);
            poll();
            xfer(1'b0, pstg_pkg::ADDR_COUNT, 0, rd);
            chk("final count", 32'hFF, rd);
            chk("held starts", 4'h9, start_out);
            xfer(1'b1, 8'h00, 32'hE000 | (cs << 10), rd);
            repeat (2) @(negedge hclk);
            chk("stop ch0", 4'h8, start_out);
            @(posedge hclk);
            xfer(1'b1, 8'h00, 32'h7000 | (cs << 10), rd);
            repeat (2) @(negedge hclk);
            chk("stop ch3", 0, start_out);
        end
        @(posedge hclk);
        xfer(1'b1, 8'h00, 32'hF100, rd);
        // Stop for ch0 lands on the very edge at which its compare of 3 would latch
        repeat (3 * div[0] - 1) @(posedge hclk);
        xfer(1'b1, 8'h00, 32'hE000, rd);
        repeat (4) @(negedge hclk);
        chk("stop with match", 0, start_out[0]);
        @(posedge hclk);
        poll();
        xfer(1'b1, 8'h00, 32'hF100, rd);
        repeat (20) @(posedge hclk);
        chk("start before reset", 1, start_out[0]);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk("reset starts", 0, start_out);
        @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, 8'h00, 0, rd);
        chk("reset trig", 32'hF000, rd);
        tally_and_finish();
    end
endmodule  // pstg_bench

// ==== tb/pstg_properties.sv ====
// Concurrent checks on the top ports of the pulse start timing generator
module pstg_properties (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [3:0]  start_out
);
    logic       ph_act, ph_wr;
    logic [7:0] ph_adr;
    logic [3:0] sel_reg;
    logic [1:0] clk_sel_reg;
    wire        trig = ph_act && ph_adr == pstg_pkg::ADDR_TRIG_CTRL;
    wire  [3:0] stop_mask = (trig && ph_wr) ? ~hwdata[pstg_pkg::STOP_LSB +: 4] : 4'h0;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) ph_act <= 1'b0;
        else ph_act <= hsel && hready && htrans == pstg_pkg::HTRANS_NONSEQ;
    end
    always_ff @(posedge hclk) begin
        ph_wr <= hwrite;
        ph_adr <= haddr[7:0];
    end
    // Mirrors of what software last wrote, taken at the same data edge as the design
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) sel_reg <= pstg_pkg::SELECT_RESET;
        else if (ph_act && ph_wr && ph_adr == pstg_pkg::ADDR_MODE_CTRL) sel_reg <= hwdata[3:0];
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) clk_sel_reg <= pstg_pkg::CLK_SEL_RESET;
        else if (trig && ph_wr) clk_sel_reg <= hwdata[pstg_pkg::CLK_SEL_LSB +: 2];
    end
    AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus stall or error");
    AST_STOP_NEGATES: assert property (stop_mask != 4'h0 |-> ##2 (start_out & $past(stop_mask, 2)) == 4'h0)
        else $error("start not negated by stop");
    AST_HELD_UNTIL_STOP: assert property (($past(start_out) & ~start_out & ~$past(stop_mask, 2) & $past(sel_reg)) == 4'h0)
        else $error("start dropped without stop");
    AST_SELECT_GATES: assert property ((start_out & ~$past(sel_reg)) == 4'h0) else $error("start on unselected channel");
    AST_STOP_READS_ONE: assert property (trig && !ph_wr |-> hrdata[pstg_pkg::STOP_LSB +: 4] == 4'hF)
        else $error("stop bits not read as one");
    AST_START_READS_ZERO: assert property (trig && !ph_wr |-> !hrdata[pstg_pkg::START_BIT]) else $error("start bit read");
    AST_CLK_SEL_READ: assert property (trig && !ph_wr |-> hrdata[pstg_pkg::CLK_SEL_LSB +: 2] == clk_sel_reg)
        else $error("clock select readback");
    AST_MODE_READ: assert property (ph_act && !ph_wr && ph_adr == pstg_pkg::ADDR_MODE_CTRL |-> hrdata[3:0] == sel_reg)
        else $error("select readback");
endmodule  // pstg_properties

bind pstg_top pstg_properties i_pstg_properties (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .start_out(start_out));

// ==== tb/pstg_pulse_model.sv ====
// Behavioural pulse generator channels fed by the start signals
module pstg_pulse_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [3:0] start,
    output logic      [3:0] pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // Toggles while started and parks low once stopped, so a lost start shows at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pulse <= 4'h0;
        else pulse <= ~pulse & start;
    end
endmodule  // pstg_pulse_model
